// file: core/timer_defs.svh
// Register offsets, field positions, reset values and counts of the down-counter timer.
// Assumes a 32-bit classic Wishbone slave with byte addresses; data sits in the low byte.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Byte offsets
`define TMR_OFF_COUNT     8'h00
`define TMR_OFF_PRESC     8'h04
`define TMR_OFF_CTRL      8'h08
`define TMR_OFF_IRQ_STAT  8'h0C
`define TMR_OFF_IRQ_MASK  8'h10

// Fields of timer_status_control
`define TMR_BIT_FLAG      7
`define TMR_BIT_IRQEN     6
`define TMR_BIT_DIROUT    5
`define TMR_BIT_LEVEL     4
`define TMR_BIT_RUN       3
`define TMR_TAP_MSB       2
`define TMR_TAP_LSB       0

// Interrupt status and mask bits
`define TMR_IRQ_ZERO      0
`define TMR_IRQ_EDGE      1
`define TMR_IRQ_W         2

// Reset values
`define TMR_COUNT_RST     8'hFF
`define TMR_PRESC_RST     7'h7F
`define TMR_CTRL_RST      8'h00

// Internal frequency divider ahead of the prescaler
`define TMR_INT_DIV       12
`define TMR_DIV_W         4

`endif

// file: core/timer_pkg.sv
// Types shared by the down-counter timer.
// Assumes timer_defs.svh for all numeric constants.
package timer_pkg;

    typedef enum logic [1:0] {
        modeEvent  = 2'b00,
        modeGated  = 2'b01,
        modeOutput = 2'b10
    } mode_t;

endpackage : timer_pkg

// file: core/timer_prescaler.sv
// Down-counting prescaler with selectable tap feeding the count register.
// Assumes the caller gives a one-cycle input tick per prescaler input edge.
`timescale 1ns/1ns
`include "timer_defs.svh"

module timer_prescaler #(
    parameter int WIDTH = 7
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic [2:0]       tapSel,
    input  wire logic             inTick,
    input  wire logic             loadEn,
    input  wire logic [WIDTH-1:0] loadValue,
    output logic      [WIDTH-1:0] value,
    output logic                  outTick
);

    // Tapped bit toggles when all bits below it borrow together
    function automatic logic tapHit(input logic [WIDTH-1:0] v, input logic [2:0] sel);
        logic [WIDTH-1:0] mask;
        mask = WIDTH'((32'h0000_0001 << sel) - 32'h0000_0001);
        if (sel == 3'h0) begin
            return 1'b1;
        end
        return (v & mask) == '0;
    endfunction : tapHit

    assign outTick = inTick && run && !loadEn && tapHit(value, tapSel);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            value <= WIDTH'(`TMR_PRESC_RST);
        end else if (!run) begin
            value <= '1;
        end else if (loadEn) begin
            value <= loadValue;
        end else if (inTick) begin
            value <= WIDTH'(value - 1'b1);
        end
    end

endmodule : timer_prescaler

// file: core/prescaled_down_counter_timer.sv
// Top of the 8-bit down-counter timer with 7-bit prescaler and one shared pin.
// Assumes a classic Wishbone master on the clock domain and a pin synchronous to it.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "timer_defs.svh"

module prescaled_down_counter_timer #(
    parameter int INT_DIV = `TMR_INT_DIV
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        timerPinIn,
    output logic             timerPinOut,
    output logic             timerPinOe,
    output logic             timerIrq,
    output logic             irq
);

    logic [7:0]               count;
    logic                     zeroFlag;
    logic                     zeroIrqEnable;
    logic                     pinDirOut;
    logic                     pinLevelData;
    logic                     prescRun;
    logic [2:0]               tapSel;
    logic [`TMR_DIV_W-1:0]    divCnt;
    logic                     divTick;
    logic                     pinPrev;
    logic                     prescIn;
    logic                     countTick;
    logic [6:0]               prescValue;
    logic [`TMR_IRQ_W-1:0]    irqStatus;
    logic [`TMR_IRQ_W-1:0]    irqMask;
    logic [`TMR_IRQ_W-1:0]    irqSet;
    timer_pkg::mode_t         mode;

    logic                     wrAccess;
    logic                     countWr;
    logic                     prescWr;
    logic                     ctrlWr;
    logic                     statWr;
    logic                     maskWr;
    logic                     zeroDec;
    logic                     flagSet;
    logic                     flagClr;
    logic                     next_zeroFlag;
    logic                     next_pinDirOut;
    logic                     next_pinLevelData;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    function automatic timer_pkg::mode_t decodeMode(input logic dirOut, input logic level);
        if (dirOut) begin
            return timer_pkg::modeOutput;
        end
        return level ? timer_pkg::modeGated : timer_pkg::modeEvent;
    endfunction : decodeMode

    // Bus slave: one wait state, write lands on the edge that sees ack
    assign wrAccess = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    assign countWr  = wrAccess && hit(adr_i, `TMR_OFF_COUNT);
    assign prescWr  = wrAccess && hit(adr_i, `TMR_OFF_PRESC);
    assign ctrlWr   = wrAccess && hit(adr_i, `TMR_OFF_CTRL);
    assign statWr   = wrAccess && hit(adr_i, `TMR_OFF_IRQ_STAT);
    assign maskWr   = wrAccess && hit(adr_i, `TMR_OFF_IRQ_MASK);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // Unmapped offsets answer with zero data
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_o) begin
            unique case (adr_i)
                `TMR_OFF_COUNT:    dat_o <= {24'h00_0000, count};
                `TMR_OFF_PRESC:    dat_o <= {25'h000_0000, prescValue};
                `TMR_OFF_CTRL:     dat_o <= {24'h00_0000, zeroFlag, zeroIrqEnable,
                                             pinDirOut, pinLevelData, prescRun, tapSel};
                `TMR_OFF_IRQ_STAT: dat_o <= {30'h0000_0000, irqStatus};
                `TMR_OFF_IRQ_MASK: dat_o <= {30'h0000_0000, irqMask};
                default:           dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Control fields
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zeroIrqEnable <= 1'b0;
            pinDirOut     <= 1'b0;
            pinLevelData  <= 1'b0;
            prescRun      <= 1'b0;
            tapSel        <= 3'h0;
        end else if (ctrlWr) begin
            zeroIrqEnable <= dat_i[`TMR_BIT_IRQEN];
            pinDirOut     <= dat_i[`TMR_BIT_DIROUT];
            pinLevelData  <= dat_i[`TMR_BIT_LEVEL];
            prescRun      <= dat_i[`TMR_BIT_RUN];
            tapSel        <= dat_i[`TMR_TAP_MSB:`TMR_TAP_LSB];
        end
    end

    assign next_pinDirOut    = ctrlWr ? dat_i[`TMR_BIT_DIROUT] : pinDirOut;
    assign next_pinLevelData = ctrlWr ? dat_i[`TMR_BIT_LEVEL] : pinLevelData;
    assign mode              = decodeMode(pinDirOut, pinLevelData);

    // Internal frequency divided by INT_DIV, twelve by default
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= '0;
        end else if (divTick) begin
            divCnt <= '0;
        end else begin
            divCnt <= `TMR_DIV_W'(divCnt + 1'b1);
        end
    end

    assign divTick = divCnt == `TMR_DIV_W'(INT_DIV - 1);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pinPrev <= 1'b0;
        end else begin
            pinPrev <= timerPinIn;
        end
    end

    // Prescaler input per mode
    always_comb begin
        unique case (mode)
            timer_pkg::modeEvent:  prescIn = timerPinIn && !pinPrev;
            timer_pkg::modeGated:  prescIn = divTick && timerPinIn;
            timer_pkg::modeOutput: prescIn = divTick;
            default:               prescIn = 1'b0;
        endcase
    end

    timer_prescaler #(
        .WIDTH(7)
    ) u_prescaler (
        .clock     (clock),
        .rst_n     (rst_n),
        .run       (prescRun),
        .tapSel    (tapSel),
        .inTick    (prescIn),
        .loadEn    (prescWr && prescRun),
        .loadValue (dat_i[6:0]),
        .value     (prescValue),
        .outTick   (countTick)
    );

    // Count register; a write overrides the decrement in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= `TMR_COUNT_RST;
        end else if (countWr) begin
            count <= dat_i[7:0];
        end else if (countTick) begin
            count <= 8'(count - 1'b1);
        end
    end

    // Zero flag; any set beats a clear in the same cycle
    assign zeroDec       = countTick && (count == 8'h01) && !countWr;
    assign flagSet       = zeroDec || (countWr && dat_i[7:0] == 8'h00)
                           || (ctrlWr && dat_i[`TMR_BIT_FLAG]);
    assign flagClr       = ctrlWr && !dat_i[`TMR_BIT_FLAG];
    assign next_zeroFlag = flagSet ? 1'b1 : (flagClr ? 1'b0 : zeroFlag);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zeroFlag <= 1'b0;
        end else begin
            zeroFlag <= next_zeroFlag;
        end
    end

    // Pin latch follows the level bit while the flag is high
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerPinOut <= 1'b0;
        end else if (next_zeroFlag) begin
            timerPinOut <= next_pinLevelData;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerPinOe <= 1'b0;
        end else begin
            timerPinOe <= next_pinDirOut;
        end
    end

    // Not gated by any power state, so it can end a processor wait
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= zeroFlag && zeroIrqEnable;
        end
    end

    // Sticky event bits, write one to clear, set wins
    assign irqSet[`TMR_IRQ_ZERO] = next_zeroFlag && !zeroFlag;
    assign irqSet[`TMR_IRQ_EDGE] = timerPinIn && !pinPrev && !pinDirOut;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= '0;
        end else begin
            irqStatus <= (irqStatus & ~(statWr ? dat_i[`TMR_IRQ_W-1:0] : '0)) | irqSet;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqMask <= '0;
        end else if (maskWr) begin
            irqMask <= dat_i[`TMR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_zero_sets_flag;
        countTick && count == 8'h01 && !countWr |=> zeroFlag && count == 8'h00;
    endproperty
    a_zero_sets_flag: assert property (p_zero_sets_flag)
        else $error("zero flag not set on decrement to zero");

    property p_irq_request;
        zeroFlag && zeroIrqEnable |=> timerIrq;
    endproperty
    a_irq_request: assert property (p_irq_request)
        else $error("timer request missing");

    property p_irq_masked;
        !zeroIrqEnable |=> !timerIrq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("timer request without enable");

    // Own gap counter, so the check follows INT_DIV in shortened sims
    logic [7:0]               divGap;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divGap <= 8'h00;
        end else if (divTick) begin
            divGap <= 8'h00;
        end else begin
            divGap <= 8'(divGap + 1'b1);
        end
    end

    property p_divide_twelve;
        divTick == (divGap == 8'(INT_DIV - 1));
    endproperty
    a_divide_twelve: assert property (p_divide_twelve)
        else $error("internal divider not twelve");

    property p_stopped;
        !prescRun && !$past(prescRun) |-> prescValue == 7'h7F && !countTick;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("prescaler not held while stopped");

    property p_gated_low;
        mode == timer_pkg::modeGated && !timerPinIn |-> !prescIn;
    endproperty
    a_gated_low: assert property (p_gated_low)
        else $error("gated mode counted with pin low");

    property p_write_zero;
        countWr && dat_i[7:0] == 8'h00 |=> zeroFlag && count == 8'h00;
    endproperty
    a_write_zero: assert property (p_write_zero)
        else $error("writing zero did not set flag");

    property p_write_wins;
        countWr && dat_i[7:0] != 8'h00 && !zeroFlag && !ctrlWr
            |=> count == $past(dat_i[7:0]) && !zeroFlag;
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("count write lost to decrement");

    property p_wrap;
        countTick && count == 8'h00 && !countWr |=> count == 8'hFF;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap");

    property p_latch_hold;
        !zeroFlag ##1 !zeroFlag |-> $stable(timerPinOut);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("pin latch changed while flag low");

    property p_latch_follow;
        zeroFlag |-> timerPinOut == pinLevelData && timerPinOe == pinDirOut;
    endproperty
    a_latch_follow: assert property (p_latch_follow)
        else $error("pin latch not transparent");

    cover property (zeroDec ##1 timerIrq);
    cover property (mode == timer_pkg::modeEvent && countTick);
    cover property (pinDirOut && $rose(timerPinOut));
    cover property (countWr && countTick && count == 8'h01);

endmodule : prescaled_down_counter_timer

// file: tb/pin_partner.sv
// Far-side model of the shared timer pin: a level source in input modes, a load otherwise.
// Assumes the bench changes the source level just after a rising clock edge.
`timescale 1ns/1ns

module pin_partner (
    input  wire logic srcLevel,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output logic      pinLevel
);
    // The timer wins the wire while it drives; the source only drives a listening pin
    assign pinLevel = pinOe ? pinOut : srcLevel;
endmodule : pin_partner

// file: tb/testbench.sv
// Self-checking bench for the prescaled down-counter timer, with a classic Wishbone master.
// Assumes the design files and pin_partner are compiled first; INT_DIV lowered to 3.
`timescale 1ns/1ns

module testbench;
    logic        clock;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        srcLevel;
    logic        pinLevel;
    logic        pinOut;
    logic        pinOe;
    logic        timerIrq;
    logic        irq;
    logic [7:0]  q;
    int          fails;
    int          comparisons;

    prescaled_down_counter_timer #(.INT_DIV(3)) DUT (
        .clock(clock), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .timerPinIn(pinLevel),
        .timerPinOut(pinOut), .timerPinOe(pinOe), .timerIrq(timerIrq), .irq(irq));

    pin_partner PIN (.srcLevel(srcLevel), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic end_of_test();
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask : ticks

    // Holds the request until ack is sampled; the timeout only guards a dead slave
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= {24'h00_0000, d};
        n = 0;
        @(posedge clock);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20) begin
            fails++;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            srcLevel <= 1'b1;
            ticks(2);
            srcLevel <= 1'b0;
            ticks(2);
        end
        ticks(4);
    endtask : pulse

    task automatic waitIrq();
        int n;
        n = 0;
        while (timerIrq !== 1'b1 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        chk({7'h00, timerIrq}, 8'h01);
    endtask : waitIrq

    task automatic t_reset();
        rd(8'h00, 8'hFF);
        rd(8'h04, 8'h7F);
        rd(8'h08, 8'h00);
        rd(8'h14, 8'h00);
        chk({5'h00, pinOe, timerIrq, irq}, 8'h00);
    endtask : t_reset

    task automatic t_flag();
        wr(8'h08, 8'h40);
        ticks(2);
        chk({7'h00, timerIrq}, 8'h00);
        wr(8'h00, 8'h00);
        rd(8'h08, 8'hC0);
        chk({7'h00, timerIrq}, 8'h01);
        wr(8'h08, 8'h40);
        wr(8'h08, 8'hC0);
        rd(8'h08, 8'hC0);
        wr(8'h08, 8'h00);
    endtask : t_flag

    task automatic t_output();
        wr(8'h00, 8'h02);
        wr(8'h08, 8'h7F);
        waitIrq();
        ticks(1);
        chk({6'h00, pinOe, pinLevel}, 8'h03);
        rd(8'h00, 8'h00);
        wr(8'h08, 8'h6F);
        ticks(2);
        chk({6'h00, pinLevel, timerIrq}, 8'h02);
        wr(8'h00, 8'h01);
        waitIrq();
        ticks(1);
        chk({7'h00, pinLevel}, 8'h00);
        wr(8'h08, 8'h00);
    endtask : t_output

    task automatic t_event();
        wr(8'h00, 8'h05);
        wr(8'h08, 8'h09);
        pulse(4);
        rd(8'h00, 8'h03);
        wr(8'h08, 8'h08);
        pulse(3);
        rd(8'h08, 8'h88);
        rd(8'h00, 8'h00);
        pulse(1);
        rd(8'h00, 8'hFF);
        rd(8'h08, 8'h88);
    endtask : t_event

    task automatic t_irq();
        rd(8'h0C, 8'h03);
        chk({7'h00, irq}, 8'h00);
        wr(8'h10, 8'h01);
        // Mask lands on the ack edge, the registered request one edge later
        ticks(2);
        chk({7'h00, irq}, 8'h01);
        wr(8'h0C, 8'h01);
        ticks(2);
        chk({7'h00, irq}, 8'h00);
        rd(8'h0C, 8'h02);
        wr(8'h10, 8'h00);
        wr(8'h0C, 8'h02);
        wr(8'h08, 8'h00);
    endtask : t_irq

    task automatic t_gated();
        wr(8'h00, 8'h40);
        wr(8'h08, 8'h18);
        ticks(30);
        rd(8'h00, 8'h40);
        @(posedge clock);
        srcLevel <= 1'b1;
        ticks(30);
        srcLevel <= 1'b0;
        bus(1'b0, 8'h00, 8'h00);
        // Thirty high cycles hold exactly ten divider ticks at INT_DIV 3
        chk(q, 8'h36);
    endtask : t_gated

    task automatic t_presc();
        wr(8'h08, 8'h08);
        wr(8'h04, 8'h55);
        rd(8'h04, 8'h55);
        wr(8'h08, 8'h00);
        rd(8'h04, 8'h7F);
        wr(8'h04, 8'h12);
        rd(8'h04, 8'h7F);
        wr(8'h00, 8'h09);
        pulse(2);
        rd(8'h00, 8'h09);
    endtask : t_presc

    // Pin edge timed so its decrement to zero meets the count write
    task automatic t_race();
        wr(8'h08, 8'h08);
        wr(8'h00, 8'h01);
        fork
            wr(8'h00, 8'h05);
            begin
                ticks(2);
                srcLevel <= 1'b1;
                ticks(2);
                srcLevel <= 1'b0;
            end
        join
        rd(8'h08, 8'h08);
        rd(8'h00, 8'h05);
    endtask : t_race

    initial begin
        #(40 * 20000);
        fails++;
        end_of_test();
    end

    initial begin
        fails = 0;
        comparisons = 0;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        srcLevel = 1'b0;
        ticks(3);
        rst_n <= 1'b1;
        t_reset();
        t_flag();
        t_output();
        t_event();
        t_irq();
        t_gated();
        t_presc();
        t_race();
        end_of_test();
    end
endmodule : testbench
